// ---- rtl/rfb_pkg.sv ----
// Constants and state type of the banked CPU register file.
// Assumes a single core clock domain and a synchronous active-low reset.
package rfb_pkg;

	// =====================================================================
	// Register widths, bank count and banked registers per bank
	// =====================================================================
	localparam int unsigned DATA_W  = 16;
	localparam int unsigned LONG_W  = 20;
	localparam int unsigned FLAGS_W = 11;
	localparam int unsigned BANKS   = 2;
	localparam int unsigned BANKED  = 7;

	// =====================================================================
	// Register selector codes; also the Avalon word index of each register
	// =====================================================================
	localparam logic [3:0] SEL_DATA0   = 4'h0;
	localparam logic [3:0] SEL_DATA1   = 4'h1;
	localparam logic [3:0] SEL_DATA2   = 4'h2;
	localparam logic [3:0] SEL_DATA3   = 4'h3;
	localparam logic [3:0] SEL_ADDR0   = 4'h4;
	localparam logic [3:0] SEL_ADDR1   = 4'h5;
	localparam logic [3:0] SEL_FRAME   = 4'h6;
	localparam logic [3:0] SEL_VECTAB  = 4'h7;
	localparam logic [3:0] SEL_INSTPTR = 4'h8;
	localparam logic [3:0] SEL_USTACK  = 4'h9;
	localparam logic [3:0] SEL_ISTACK  = 4'ha;
	localparam logic [3:0] SEL_STATIC  = 4'hb;
	localparam logic [3:0] SEL_FLAGS   = 4'hc;
	localparam logic [3:0] BUS_PAIR_LO = 4'hd;
	localparam logic [3:0] BUS_PAIR_HI = 4'he;
	localparam logic [3:0] BUS_APAIR   = 4'hf;

	// =====================================================================
	// Access widths
	// =====================================================================
	localparam logic [1:0] W_BYTE_LO = 2'h0;
	localparam logic [1:0] W_BYTE_HI = 2'h1;
	localparam logic [1:0] W_WORD    = 2'h2;
	localparam logic [1:0] W_LONG    = 2'h3;

	// =====================================================================
	// Flag bit positions
	// =====================================================================
	localparam int unsigned FLAG_C   = 0;
	localparam int unsigned FLAG_D   = 1;
	localparam int unsigned FLAG_Z   = 2;
	localparam int unsigned FLAG_S   = 3;
	localparam int unsigned FLAG_B   = 4;
	localparam int unsigned FLAG_O   = 5;
	localparam int unsigned FLAG_I   = 6;
	localparam int unsigned FLAG_U   = 7;
	localparam int unsigned PRIO_LSB = 8;
	localparam int unsigned PRIO_MSB = 10;

	// =====================================================================
	// Reset values
	// =====================================================================
	localparam logic [DATA_W-1:0]  RST_DATA  = 16'h0000;
	localparam logic [LONG_W-1:0]  RST_LONG  = 20'h00000;
	localparam logic [FLAGS_W-1:0] RST_FLAGS = 11'h000;

	// Whole state of the register file.
	typedef struct packed {
		logic [BANKS-1:0][BANKED-1:0][DATA_W-1:0] bank;
		logic [LONG_W-1:0]                        vectab;
		logic [LONG_W-1:0]                        instptr;
		logic [DATA_W-1:0]                        ustack;
		logic [DATA_W-1:0]                        istack;
		logic [DATA_W-1:0]                        static_base;
		logic [FLAGS_W-1:0]                       flags;
		logic [DATA_W-1:0]                        stack_act;
		logic                                     wait_req;
		logic [31:0]                              bus_rdata;
		logic [31:0]                              dp_rdata;
		logic                                     irq_accept;
	} rfb_state_t;

endpackage

// ---- rtl/rfb_regfile.sv ----
// Banked CPU register file with an Avalon-MM slave and a datapath port.
// Assumes datapath and bus run on core_clk_i; all inputs are synchronous to it.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module rfb_regfile #(
	parameter logic [19:0] RESET_INSTPTR = 20'h00000
) (
	// Clock and reset.
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// Avalon-MM slave, word addressed.
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Datapath read port.
	input  wire logic [3:0]  dp_rsel_i,
	input  wire logic [1:0]  dp_rwidth_i,
	output logic      [31:0] dp_rdata_o,
	// Datapath write port.
	input  wire logic        dp_wr_i,
	input  wire logic [3:0]  dp_wsel_i,
	input  wire logic [1:0]  dp_wwidth_i,
	input  wire logic [31:0] dp_wdata_i,
	// ALU flag update.
	input  wire logic        alu_upd_i,
	input  wire logic [1:0]  alu_width_i,
	input  wire logic [31:0] alu_result_i,
	input  wire logic        alu_carry_i,
	input  wire logic        alu_ovf_i,
	// Interrupt handshake.
	input  wire logic        irq_req_i,
	input  wire logic [2:0]  irq_prio_i,
	input  wire logic        irq_ack_i,
	output logic             irq_accept_o,
	// Processor state.
	output logic      [10:0] flags_o,
	output logic      [15:0] stack_ptr_o,
	output logic      [19:0] instptr_o,
	output logic      [19:0] vectab_o
);

	// =====================================================================
	// Elaboration check
	// =====================================================================
	// The instruction pointer reset value must be a defined value; only its two low bits are checked for X.
	if (RESET_INSTPTR[1:0] === 2'bxx) begin : g_bad_reset
		$error("RESET_INSTPTR must be a defined value.");
	end

	// =====================================================================
	// Access functions
	// =====================================================================
	// Reads one register or pair from the bank chosen by the current bank flag.
	function automatic logic [31:0] rd_reg(input rfb_pkg::rfb_state_t s, input logic [3:0] sel,
					      input logic [1:0] w);
		logic        b;
		logic [15:0] v;
		logic [31:0] r;
		b = s.flags[rfb_pkg::FLAG_B];
		v = 16'h0000;
		r = 32'h0000_0000;
		if (sel <= rfb_pkg::SEL_FRAME) begin
			v = s.bank[b][sel[2:0]];
		end
		unique case (sel)
			rfb_pkg::SEL_VECTAB:  r = {12'h000, s.vectab};
			rfb_pkg::SEL_INSTPTR: r = {12'h000, s.instptr};
			rfb_pkg::SEL_USTACK:  r = {16'h0000, s.ustack};
			rfb_pkg::SEL_ISTACK:  r = {16'h0000, s.istack};
			rfb_pkg::SEL_STATIC:  r = {16'h0000, s.static_base};
			rfb_pkg::SEL_FLAGS:   r = {21'h0, s.flags};
			default: begin
				unique case (w)
					rfb_pkg::W_BYTE_LO: r = {24'h000000, v[7:0]};
					rfb_pkg::W_BYTE_HI: r = {24'h000000, v[15:8]};
					rfb_pkg::W_WORD:    r = {16'h0000, v};
					rfb_pkg::W_LONG: begin
						if (sel == rfb_pkg::SEL_DATA0 || sel == rfb_pkg::SEL_DATA1) begin
							r = {s.bank[b][sel[2:0] + 3'h2], v};
						end else if (sel == rfb_pkg::SEL_ADDR0) begin
							r = {s.bank[b][3'h5], v};
						end else begin
							r = {16'h0000, v};
						end
					end
				endcase
			end
		endcase
		return r;
	endfunction

	// Writes one register or pair; of the banked registers, byte writes reach data registers 0 and 1 only.
	function automatic rfb_pkg::rfb_state_t wr_reg(input rfb_pkg::rfb_state_t s, input logic [3:0] sel,
						       input logic [1:0] w, input logic [31:0] d);
		logic                b;
		rfb_pkg::rfb_state_t n;
		n = s;
		b = s.flags[rfb_pkg::FLAG_B];
		if (sel <= rfb_pkg::SEL_FRAME) begin
			unique case (w)
				rfb_pkg::W_BYTE_LO: begin
					if (sel == rfb_pkg::SEL_DATA0 || sel == rfb_pkg::SEL_DATA1) begin
						n.bank[b][sel[2:0]][7:0] = d[7:0];
					end
				end
				rfb_pkg::W_BYTE_HI: begin
					if (sel == rfb_pkg::SEL_DATA0 || sel == rfb_pkg::SEL_DATA1) begin
						n.bank[b][sel[2:0]][15:8] = d[7:0];
					end
				end
				rfb_pkg::W_WORD: n.bank[b][sel[2:0]] = d[15:0];
				rfb_pkg::W_LONG: begin
					n.bank[b][sel[2:0]] = d[15:0];
					if (sel == rfb_pkg::SEL_DATA0 || sel == rfb_pkg::SEL_DATA1) begin
						n.bank[b][sel[2:0] + 3'h2] = d[31:16];
					end else if (sel == rfb_pkg::SEL_ADDR0) begin
						n.bank[b][3'h5] = d[31:16];
					end
				end
			endcase
		end
		unique case (sel)
			rfb_pkg::SEL_VECTAB:  n.vectab = d[19:0];
			rfb_pkg::SEL_INSTPTR: n.instptr = d[19:0];
			rfb_pkg::SEL_USTACK:  n.ustack = d[15:0];
			rfb_pkg::SEL_ISTACK:  n.istack = d[15:0];
			rfb_pkg::SEL_STATIC:  n.static_base = d[15:0];
			rfb_pkg::SEL_FLAGS:   n.flags = d[10:0];
			default: n.flags = n.flags;
		endcase
		return n;
	endfunction

	// =====================================================================
	// State
	// =====================================================================
	rfb_pkg::rfb_state_t st;
	rfb_pkg::rfb_state_t next_st;
	logic                bus_req;
	logic                bus_done;
	logic [3:0]          bus_sel;
	logic [1:0]          bus_width;
	logic [31:0]         alu_masked;
	logic                alu_sign;

	// Bus request decode; word indices 0 to 12 map straight to a selector code, the three pair indices to a long access.
	always_comb begin
		bus_req   = avs_read_i | avs_write_i;
		bus_done  = bus_req & ~st.wait_req;
		bus_sel   = avs_address_i;
		bus_width = rfb_pkg::W_WORD;
		if (avs_address_i == rfb_pkg::BUS_PAIR_LO) begin
			bus_sel   = rfb_pkg::SEL_DATA0;
			bus_width = rfb_pkg::W_LONG;
		end else if (avs_address_i == rfb_pkg::BUS_PAIR_HI) begin
			bus_sel   = rfb_pkg::SEL_DATA1;
			bus_width = rfb_pkg::W_LONG;
		end else if (avs_address_i == rfb_pkg::BUS_APAIR) begin
			bus_sel   = rfb_pkg::SEL_ADDR0;
			bus_width = rfb_pkg::W_LONG;
		end
	end

	// ALU result masked to the operation width, and its sign bit.
	always_comb begin
		unique case (alu_width_i)
			rfb_pkg::W_WORD: begin
				alu_masked = {16'h0000, alu_result_i[15:0]};
				alu_sign   = alu_result_i[15];
			end
			rfb_pkg::W_LONG: begin
				alu_masked = alu_result_i;
				alu_sign   = alu_result_i[31];
			end
			default: begin
				alu_masked = {24'h000000, alu_result_i[7:0]};
				alu_sign   = alu_result_i[7];
			end
		endcase
	end

	// Next state: bus write, then datapath write, then ALU flags, then interrupt acknowledge.
	always_comb begin
		next_st = st;
		// Waitrequest drops for one cycle after a request is seen.
		next_st.wait_req  = ~(bus_req & st.wait_req);
		next_st.bus_rdata = rd_reg(st, bus_sel, bus_width);
		if (bus_done && avs_write_i) begin
			next_st = wr_reg(next_st, bus_sel, bus_width, avs_writedata_i);
		end
		next_st.dp_rdata = rd_reg(st, dp_rsel_i, dp_rwidth_i);
		if (dp_wr_i) begin
			next_st = wr_reg(next_st, dp_wsel_i, dp_wwidth_i, dp_wdata_i);
		end
		if (alu_upd_i) begin
			next_st.flags[rfb_pkg::FLAG_C] = alu_carry_i;
			next_st.flags[rfb_pkg::FLAG_Z] = (alu_masked == 32'h0000_0000);
			next_st.flags[rfb_pkg::FLAG_S] = alu_sign;
			next_st.flags[rfb_pkg::FLAG_O] = alu_ovf_i;
		end
		if (irq_ack_i) begin
			next_st.flags[rfb_pkg::FLAG_U] = 1'b0;
			next_st.flags[rfb_pkg::FLAG_I] = 1'b0;
		end
		next_st.stack_act = next_st.flags[rfb_pkg::FLAG_U] ? next_st.ustack : next_st.istack;
		next_st.irq_accept = irq_req_i & st.flags[rfb_pkg::FLAG_I]
				   & (irq_prio_i > st.flags[rfb_pkg::PRIO_MSB:rfb_pkg::PRIO_LSB]);
	end

	// State register.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			st             <= '0;
			st.bank        <= {(rfb_pkg::BANKS * rfb_pkg::BANKED){rfb_pkg::RST_DATA}};
			st.vectab      <= rfb_pkg::RST_LONG;
			st.instptr     <= RESET_INSTPTR;
			st.flags       <= rfb_pkg::RST_FLAGS;
			st.wait_req    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs are taken straight from the state register.
	assign avs_readdata_o    = st.bus_rdata;
	assign avs_waitrequest_o = st.wait_req;
	assign dp_rdata_o        = st.dp_rdata;
	assign irq_accept_o      = st.irq_accept;
	assign flags_o           = st.flags;
	assign stack_ptr_o       = st.stack_act;
	assign instptr_o         = st.instptr;
	assign vectab_o          = st.vectab;

	// =====================================================================
	// Assertions
	// =====================================================================
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_bank_route;
		dp_wr_i && dp_wsel_i == rfb_pkg::SEL_DATA3 && dp_wwidth_i == rfb_pkg::W_WORD
		|=> st.bank[$past(st.flags[rfb_pkg::FLAG_B])][3] == $past(dp_wdata_i[15:0]);
	endproperty
	a_bank_route: assert property (p_bank_route) else $error("Banked write missed its bank.");

	property p_byte_keep;
		(dp_wr_i && dp_wsel_i == rfb_pkg::SEL_DATA0 && dp_wwidth_i == rfb_pkg::W_BYTE_LO
		 && !(bus_done && avs_write_i))
		|=> st.bank[st.flags[rfb_pkg::FLAG_B]][0][15:8] == $past(st.bank[st.flags[rfb_pkg::FLAG_B]][0][15:8]);
	endproperty
	a_byte_keep: assert property (p_byte_keep) else $error("Low byte write disturbed the upper byte.");

	property p_pair_read;
		(dp_rsel_i == rfb_pkg::SEL_DATA1 && dp_rwidth_i == rfb_pkg::W_LONG)
		|=> dp_rdata_o == {$past(st.bank[st.flags[rfb_pkg::FLAG_B]][3]), $past(st.bank[st.flags[rfb_pkg::FLAG_B]][1])};
	endproperty
	a_pair_read: assert property (p_pair_read) else $error("Upper data pair read wrong.");

	property p_zero;
		alu_upd_i && alu_width_i == rfb_pkg::W_WORD && alu_result_i[15:0] == 16'h0000 |=> flags_o[rfb_pkg::FLAG_Z];
	endproperty
	a_zero: assert property (p_zero) else $error("Zero result did not set the zero flag.");

	property p_sign;
		alu_upd_i |=> flags_o[rfb_pkg::FLAG_S] == $past(alu_sign) && !(flags_o[rfb_pkg::FLAG_Z] && flags_o[rfb_pkg::FLAG_S]);
	endproperty
	a_sign: assert property (p_sign) else $error("Sign flag does not follow the result.");

	property p_carry;
		alu_upd_i |=> flags_o[rfb_pkg::FLAG_C] == $past(alu_carry_i) && flags_o[rfb_pkg::FLAG_O] == $past(alu_ovf_i);
	endproperty
	a_carry: assert property (p_carry) else $error("Carry or overflow not captured.");

	property p_ack_stack;
		irq_ack_i |=> !flags_o[rfb_pkg::FLAG_U] && stack_ptr_o == st.istack;
	endproperty
	a_ack_stack: assert property (p_ack_stack) else $error("Acknowledge did not select the interrupt stack.");

	property p_ack_enable;
		irq_ack_i |=> !flags_o[rfb_pkg::FLAG_I] ##1 !irq_accept_o;
	endproperty
	a_ack_enable: assert property (p_ack_enable) else $error("Acknowledge left interrupts enabled.");

	property p_prio;
		irq_accept_o |-> $past(irq_prio_i) > $past(st.flags[rfb_pkg::PRIO_MSB:rfb_pkg::PRIO_LSB])
				&& $past(st.flags[rfb_pkg::FLAG_I]);
	endproperty
	a_prio: assert property (p_prio) else $error("Interrupt accepted at or below the level.");

	property p_bank_switch;
		$rose(flags_o[rfb_pkg::FLAG_B]) && !$past(dp_wr_i) |-> st.bank == $past(st.bank);
	endproperty
	a_bank_switch: assert property (p_bank_switch) else $error("Bank switch changed register contents.");

	property p_wait;
		bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("Bus answer not given in one cycle.");

	property p_addr_pair;
		dp_wr_i && dp_wsel_i == rfb_pkg::SEL_ADDR0 && dp_wwidth_i == rfb_pkg::W_LONG
		|=> st.bank[$past(st.flags[rfb_pkg::FLAG_B])][5] == $past(dp_wdata_i[31:16]);
	endproperty
	a_addr_pair: assert property (p_addr_pair) else $error("Long address write missed the upper half.");

	property p_accept;
		irq_req_i && st.flags[rfb_pkg::FLAG_I]
		&& irq_prio_i > st.flags[rfb_pkg::PRIO_MSB:rfb_pkg::PRIO_LSB] |=> irq_accept_o;
	endproperty
	a_accept: assert property (p_accept) else $error("Interrupt above the level was refused.");

	property p_vectab;
		bus_done && avs_write_i && avs_address_i == rfb_pkg::SEL_VECTAB
		&& !(dp_wr_i && dp_wsel_i == rfb_pkg::SEL_VECTAB)
		|=> vectab_o == $past(avs_writedata_i[19:0]);
	endproperty
	a_vectab: assert property (p_vectab) else $error("Bus write missed the vector table base.");

	c_bank1_write: cover property (dp_wr_i && st.flags[rfb_pkg::FLAG_B]);
	c_pair_read:   cover property (bus_done && avs_read_i && avs_address_i == rfb_pkg::BUS_APAIR);
	c_irq_accept:  cover property (irq_accept_o ##1 irq_ack_i);
	c_bus_write:   cover property (bus_done && avs_write_i && avs_address_i == rfb_pkg::SEL_FLAGS);

endmodule

`default_nettype wire

// ---- tb/rfb_dp_model.sv ----
// Behavioural model of the execution datapath and decoder facing the register file.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
`default_nettype none

module rfb_dp_model (
	// Clock and read-back.
	input  wire logic        core_clk_i,
	input  wire logic [31:0] dp_rdata_i,
	// Datapath requests.
	output logic      [3:0]  dp_rsel_o,
	output logic      [1:0]  dp_rwidth_o,
	output logic             dp_wr_o,
	output logic      [3:0]  dp_wsel_o,
	output logic      [1:0]  dp_wwidth_o,
	output logic      [31:0] dp_wdata_o,
	// ALU flag update.
	output logic             alu_upd_o,
	output logic      [1:0]  alu_width_o,
	output logic      [31:0] alu_result_o,
	output logic             alu_carry_o,
	output logic             alu_ovf_o,
	// Interrupt side.
	output logic             irq_req_o,
	output logic      [2:0]  irq_prio_o,
	output logic             irq_ack_o
);
	// Idle values at time zero.
	initial begin
		{dp_rsel_o, dp_rwidth_o, dp_wr_o, dp_wsel_o, dp_wwidth_o, dp_wdata_o} = '0;
		{alu_upd_o, alu_width_o, alu_result_o, alu_carry_o, alu_ovf_o} = '0;
		{irq_req_o, irq_prio_o, irq_ack_o} = '0;
	end

	// One-cycle write; stale data is inverted so nothing relies on its hold.
	task automatic dp_write(input logic [3:0] sel, input logic [1:0] wid, input logic [31:0] d);
		@(posedge core_clk_i);
		dp_wr_o     <= 1'b1;
		dp_wsel_o   <= sel;
		dp_wwidth_o <= wid;
		dp_wdata_o  <= (sel == rfb_pkg::SEL_FLAGS) ? (d & 32'hfffffffd) : d;
		@(posedge core_clk_i);
		dp_wr_o     <= 1'b0;
		dp_wdata_o  <= ~d;
	endtask

	// Presents a selector and takes the registered answer one edge later.
	task automatic dp_read(input logic [3:0] sel, input logic [1:0] wid, output logic [31:0] d);
		@(posedge core_clk_i);
		dp_rsel_o   <= sel;
		dp_rwidth_o <= wid;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		d = dp_rdata_i;
	endtask

	// One ALU result pulse.
	task automatic alu_op(input logic [1:0] wid, input logic [31:0] res, input logic c, input logic v);
		@(posedge core_clk_i);
		alu_upd_o    <= 1'b1;
		alu_width_o  <= wid;
		alu_result_o <= res;
		alu_carry_o  <= c;
		alu_ovf_o    <= v;
		@(posedge core_clk_i);
		alu_upd_o    <= 1'b0;
		alu_result_o <= ~res;
	endtask

	// Interrupt request level and acknowledge pulse.
	task automatic irq_set(input logic req, input logic [2:0] prio);
		@(posedge core_clk_i);
		irq_req_o  <= req;
		irq_prio_o <= prio;
	endtask
	task automatic irq_pulse();
		@(posedge core_clk_i);
		irq_ack_o <= 1'b1;
		@(posedge core_clk_i);
		irq_ack_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the banked register file with an Avalon master and a datapath model.
// Assumes one 50 MHz core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        core_clk_i;
	logic        rst_n_i;
	logic [3:0]  a_addr;
	logic        a_rd;
	logic        a_wr;
	logic [31:0] a_wdata;
	logic [31:0] a_rdata;
	logic        a_wait;
	logic [3:0]  rsel;
	logic [1:0]  rwid;
	logic [31:0] rdata;
	logic        wr;
	logic [3:0]  wsel;
	logic [1:0]  wwid;
	logic [31:0] wdata;
	logic        upd;
	logic [1:0]  uwid;
	logic [31:0] ures;
	logic        uc;
	logic        uv;
	logic        req;
	logic [2:0]  prio;
	logic        ack;
	logic        accept;
	logic [10:0] flags;
	logic [15:0] sp;
	logic [19:0] ip;
	logic [19:0] vt;
	logic [31:0] rd;
	int          err_total;
	int          check_count;

	rfb_regfile dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(a_addr), .avs_read_i(a_rd),
		.avs_write_i(a_wr), .avs_writedata_i(a_wdata), .avs_readdata_o(a_rdata), .avs_waitrequest_o(a_wait),
		.dp_rsel_i(rsel), .dp_rwidth_i(rwid), .dp_rdata_o(rdata), .dp_wr_i(wr), .dp_wsel_i(wsel),
		.dp_wwidth_i(wwid), .dp_wdata_i(wdata), .alu_upd_i(upd), .alu_width_i(uwid), .alu_result_i(ures),
		.alu_carry_i(uc), .alu_ovf_i(uv), .irq_req_i(req), .irq_prio_i(prio), .irq_ack_i(ack),
		.irq_accept_o(accept), .flags_o(flags), .stack_ptr_o(sp), .instptr_o(ip), .vectab_o(vt));

	rfb_dp_model dp (.core_clk_i(core_clk_i), .dp_rdata_i(rdata), .dp_rsel_o(rsel), .dp_rwidth_o(rwid),
		.dp_wr_o(wr), .dp_wsel_o(wsel), .dp_wwidth_o(wwid), .dp_wdata_o(wdata), .alu_upd_o(upd),
		.alu_width_o(uwid), .alu_result_o(ures), .alu_carry_o(uc), .alu_ovf_o(uv), .irq_req_o(req),
		.irq_prio_o(prio), .irq_ack_o(ack));

	// =====================================================================
	// Shared tasks
	// =====================================================================
	// Compares one value and counts the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Avalon transfer held until waitrequest is sampled low.
	task automatic av_xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge core_clk_i);
		a_addr  <= a;
		a_wr    <= w;
		a_rd    <= !w;
		a_wdata <= d;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (a_wait !== 1'b0);
		q = a_rdata;
		check(n, 32'h2);
		a_rd    <= 1'b0;
		a_wr    <= 1'b0;
		a_wdata <= ~d;
	endtask
	task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		av_xfer(1'b1, a, d, q);
	endtask
	task automatic av_rd(input logic [3:0] a, output logic [31:0] q);
		av_xfer(1'b0, a, 32'h0, q);
	endtask

	// =====================================================================
	// Scenarios
	// =====================================================================
	task automatic t_reset();
		check({31'h0, a_wait}, 32'h1);
		check({21'h0, flags}, 32'h0);
		check({12'h0, ip}, 32'h0);
		for (int i = 0; i < 13; i++) begin
			av_rd(4'(i), rd);
			check(rd, 32'h0);
		end
		$display("test reset done");
	endtask

	task automatic t_widths();
		for (int i = 0; i < 13; i++) begin
			av_wr(4'(i), 32'hfffffffd);
			av_rd(4'(i), rd);
			check(rd, (i == 7 || i == 8) ? 32'h000ffffd : (i == 12) ? 32'h000007fd : 32'h0000fffd);
		end
		check({12'h0, vt}, 32'h000ffffd);
		check({12'h0, ip}, 32'h000ffffd);
		av_wr(rfb_pkg::SEL_FLAGS, 32'h0);
		av_wr(rfb_pkg::BUS_PAIR_LO, 32'h12345678);
		av_rd(rfb_pkg::SEL_DATA2, rd);
		check(rd, 32'h1234);
		av_rd(rfb_pkg::SEL_DATA0, rd);
		check(rd, 32'h5678);
		av_rd(rfb_pkg::BUS_PAIR_LO, rd);
		check(rd, 32'h12345678);
		av_wr(rfb_pkg::BUS_PAIR_HI, 32'h9abcdef0);
		av_rd(rfb_pkg::SEL_DATA3, rd);
		check(rd, 32'h9abc);
		av_wr(rfb_pkg::BUS_APAIR, 32'hcafe0123);
		av_rd(rfb_pkg::SEL_ADDR1, rd);
		check(rd, 32'hcafe);
		av_rd(rfb_pkg::BUS_APAIR, rd);
		check(rd, 32'hcafe0123);
		$display("test widths done");
	endtask

	task automatic t_bytes();
		dp.dp_write(rfb_pkg::SEL_DATA0, rfb_pkg::W_WORD, 32'h1234);
		dp.dp_write(rfb_pkg::SEL_DATA0, rfb_pkg::W_BYTE_HI, 32'habab);
		dp.dp_read(rfb_pkg::SEL_DATA0, rfb_pkg::W_WORD, rd);
		check(rd, 32'hab34);
		dp.dp_write(rfb_pkg::SEL_DATA0, rfb_pkg::W_BYTE_LO, 32'h0056);
		dp.dp_read(rfb_pkg::SEL_DATA0, rfb_pkg::W_BYTE_HI, rd);
		check(rd, 32'hab);
		dp.dp_write(rfb_pkg::SEL_DATA1, rfb_pkg::W_WORD, 32'h5678);
		dp.dp_write(rfb_pkg::SEL_DATA1, rfb_pkg::W_BYTE_LO, 32'hcdcd);
		dp.dp_read(rfb_pkg::SEL_DATA1, rfb_pkg::W_WORD, rd);
		check(rd, 32'h56cd);
		dp.dp_read(rfb_pkg::SEL_DATA1, rfb_pkg::W_BYTE_LO, rd);
		check(rd, 32'hcd);
		dp.dp_read(rfb_pkg::SEL_DATA1, rfb_pkg::W_LONG, rd);
		check(rd, 32'h9abc56cd);
		dp.dp_write(rfb_pkg::SEL_DATA0, rfb_pkg::W_LONG, 32'h11112222);
		dp.dp_read(rfb_pkg::SEL_DATA2, rfb_pkg::W_WORD, rd);
		check(rd, 32'h1111);
		dp.dp_write(rfb_pkg::SEL_ADDR0, rfb_pkg::W_LONG, 32'h33334444);
		dp.dp_read(rfb_pkg::SEL_ADDR0, rfb_pkg::W_LONG, rd);
		check(rd, 32'h33334444);
		dp.dp_write(rfb_pkg::SEL_ADDR0, rfb_pkg::W_BYTE_LO, 32'h00ff);
		dp.dp_read(rfb_pkg::SEL_ADDR0, rfb_pkg::W_LONG, rd);
		check(rd, 32'h33334444);
		$display("test bytes done");
	endtask

	task automatic t_bank();
		dp.dp_write(rfb_pkg::SEL_FRAME, rfb_pkg::W_WORD, 32'h0f0f);
		av_wr(rfb_pkg::SEL_STATIC, 32'h5a5a);
		dp.dp_write(rfb_pkg::SEL_FLAGS, rfb_pkg::W_WORD, 32'h0010);
		dp.dp_write(rfb_pkg::SEL_DATA0, rfb_pkg::W_WORD, 32'h7777);
		dp.dp_write(rfb_pkg::SEL_DATA3, rfb_pkg::W_WORD, 32'h3333);
		check({21'h0, flags}, 32'h0010);
		dp.dp_read(rfb_pkg::SEL_DATA0, rfb_pkg::W_WORD, rd);
		check(rd, 32'h7777);
		dp.dp_read(rfb_pkg::SEL_FRAME, rfb_pkg::W_WORD, rd);
		check(rd, 32'h0);
		av_rd(rfb_pkg::SEL_STATIC, rd);
		check(rd, 32'h5a5a);
		dp.dp_write(rfb_pkg::SEL_FLAGS, rfb_pkg::W_WORD, 32'h0);
		av_rd(rfb_pkg::SEL_DATA0, rd);
		check(rd, 32'h2222);
		av_rd(rfb_pkg::SEL_DATA3, rd);
		check(rd, 32'h9abc);
		dp.dp_read(rfb_pkg::SEL_FRAME, rfb_pkg::W_WORD, rd);
		check(rd, 32'h0f0f);
		$display("test bank done");
	endtask

	task automatic t_alu();
		logic [1:0]  wid [4] = '{rfb_pkg::W_WORD, rfb_pkg::W_WORD, rfb_pkg::W_BYTE_LO, rfb_pkg::W_LONG};
		logic [31:0] res [4] = '{32'h0, 32'h8000, 32'h100, 32'h80000000};
		logic [3:0]  exp [4] = '{4'h3, 4'hc, 4'hb, 4'h4};
		for (int i = 0; i < 4; i++) begin
			dp.alu_op(wid[i], res[i], exp[i][0], exp[i][3]);
			@(negedge core_clk_i);
			check({28'h0, flags[5], flags[3], flags[2], flags[0]}, {28'h0, exp[i]});
		end
		$display("test alu done");
	endtask

	task automatic t_irq();
		av_wr(rfb_pkg::SEL_USTACK, 32'haaaa);
		av_wr(rfb_pkg::SEL_ISTACK, 32'h5555);
		av_wr(rfb_pkg::SEL_FLAGS, 32'h0380);
		dp.irq_set(1'b1, 3'h7);
		repeat (2) @(negedge core_clk_i);
		check({31'h0, accept}, 32'h0);
		check({16'h0, sp}, 32'haaaa);
		av_wr(rfb_pkg::SEL_FLAGS, 32'h03c0);
		dp.irq_set(1'b1, 3'h3);
		repeat (2) @(negedge core_clk_i);
		check({31'h0, accept}, 32'h0);
		dp.irq_set(1'b1, 3'h4);
		repeat (2) @(negedge core_clk_i);
		check({31'h0, accept}, 32'h1);
		dp.irq_set(1'b0, 3'h0);
		dp.irq_pulse();
		repeat (2) @(negedge core_clk_i);
		check({21'h0, flags}, 32'h0300);
		check({16'h0, sp}, 32'h5555);
		$display("test irq done");
	endtask

	// Clock generator.
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	// Watchdog well beyond the expected run of a few hundred cycles.
	initial begin
		#400000;
		err_total++;
		test_done();
	end

	// Reset, then the scenarios in order.
	initial begin
		{rst_n_i, a_addr, a_rd, a_wr, a_wdata} = '0;
		err_total   = 0;
		check_count = 0;
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(negedge core_clk_i);
		t_reset();
		t_widths();
		t_bytes();
		t_bank();
		t_alu();
		t_irq();
		test_done();
	end
endmodule
`default_nettype wire
